// ---- rtl/cfg_pkg.sv ----
package cfg_pkg;
    // configuration byte locations in the special purpose area
    localparam logic [15:0] ADDR_BYTE_ZERO = 16'h2018;
    localparam logic [15:0] ADDR_BYTE_ONE = 16'h201A;
    localparam logic [15:0] ADDR_BYTE_TWO = 16'h201C;
    // apb register byte addresses
    localparam logic [15:0] OFS_BYTE_TWO = 16'h201C;
    localparam logic [15:0] OFS_BYTE_ZERO = 16'h2018;
    localparam logic [15:0] OFS_BYTE_ONE = 16'h2020;
    localparam logic [15:0] OFS_STATUS = 16'h2024;
    // field positions
    localparam int B0_WIDTH_LOW = 1;
    localparam int B0_READY0 = 4;
    localparam int B0_READY1 = 5;
    localparam int B0_LOCK0 = 6;
    localparam int B0_LOCK1 = 7;
    localparam int B1_FETCH_THIRD = 0;
    localparam int B1_READY2 = 1;
    localparam int B1_WIDTH_HIGH = 2;
    localparam int B1_TIMING0 = 6;
    localparam int B1_TIMING1 = 7;
    localparam int B2_ADDR_WIDTH = 1;
    localparam int B2_MIRROR = 2;
    // byte two value seen when the byte is absent or not fetched
    localparam logic [7:0] BYTE_TWO_DEFAULT = 8'hF8;
    localparam logic [7:0] BYTE_TWO_GOOD_MASK = 8'hF9;
    localparam logic [7:0] BYTE_TWO_GOOD_VAL = 8'hF8;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    // decoded encodings
    localparam logic [1:0] TIMING_MODE0 = 2'h0;
    localparam logic [1:0] TIMING_MODE3 = 2'h3;
    localparam logic [1:0] WIDTH_ILLEGAL = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_8 = 2'h2;
    localparam logic [1:0] WIDTH_PIN = 2'h3;
    localparam logic [2:0] READY_UNLIMITED = 3'h7;
    localparam logic [2:0] READY_ZERO = 3'h0;
    localparam logic [1:0] AUTO_WAIT_MODE0 = 2'h1;
    localparam logic [1:0] AUTO_WAIT_NONE = 2'h0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        PROT_RW = 2'h0,
        PROT_WRITE = 2'h1,
        PROT_READ = 2'h2,
        PROT_NONE = 2'h3
    } prot_t;

    typedef enum {
        ST_IDLE, ST_REQ0, ST_WAIT0, ST_REQ1, ST_WAIT1, ST_REQ2, ST_WAIT2, ST_DONE
    } load_state_t;

    // decoded settings handed to the bus controller and memory map
    typedef struct packed {
        logic [1:0] timing_mode;
        logic [1:0] auto_wait;
        logic [2:0] ready_max;
        logic ready_unlimited;
        logic [1:0] width_mode;
        logic addr_width_select;
        logic low_segment_mirror;
        prot_t prot;
        logic cfg_error;
    } cfg_out_t;

    // configuration memory read port
    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } mem_req_t;
endpackage

// ---- rtl/cfg_decode.sv ----
`timescale 1ns/1ps
// pure decode of the three bytes into bus settings
module cfg_decode
    import cfg_pkg::*;
(
    input wire logic [7:0] byte_zero,
    input wire logic [7:0] byte_one,
    input wire logic [7:0] byte_two,
    input wire logic large_variant,
    output cfg_out_t dec
);
    logic [1:0] tsel;
    logic [2:0] rdy;
    logic [1:0] lock;
    logic [7:0] b2;

    always_comb begin
        // smaller variant forces both timing bits high
        tsel = large_variant ? {byte_one[B1_TIMING1], byte_one[B1_TIMING0]} : TIMING_MODE3;
        rdy = {byte_one[B1_READY2], byte_zero[B0_READY1], byte_zero[B0_READY0]};
        lock = {byte_zero[B0_LOCK1], byte_zero[B0_LOCK0]};
        b2 = large_variant ? byte_two : BYTE_TWO_DEFAULT;
        dec = '0;
        dec.timing_mode = tsel;
        // mode 0 always adds one wait, mode 3 adds none
        dec.auto_wait = (tsel == TIMING_MODE0) ? AUTO_WAIT_MODE0 : AUTO_WAIT_NONE;
        // 000 zero, 100..110 one to three, 111 unlimited
        if (rdy == READY_UNLIMITED) begin
            dec.ready_unlimited = 1'b1;
            dec.ready_max = READY_ZERO;
        end else if (rdy[2]) begin
            dec.ready_unlimited = 1'b0;
            dec.ready_max = 3'((rdy & 3'h3) + 3'h1);
        end else begin
            dec.ready_unlimited = 1'b0;
            dec.ready_max = READY_ZERO;
        end
        dec.width_mode = {byte_one[B1_WIDTH_HIGH], byte_zero[B0_WIDTH_LOW]};
        dec.addr_width_select = b2[B2_ADDR_WIDTH];
        dec.low_segment_mirror = b2[B2_MIRROR];
        dec.prot = prot_t'(lock);
        // reserved encodings flag an undefined configuration
        dec.cfg_error = (tsel != TIMING_MODE0 && tsel != TIMING_MODE3)
            || (dec.width_mode == WIDTH_ILLEGAL) || (rdy[2] == 1'b0 && rdy != READY_ZERO)
            || ((b2 & BYTE_TWO_GOOD_MASK) != BYTE_TWO_GOOD_VAL);
    end
endmodule // cfg_decode

// ---- rtl/apb_cfg_regs.sv ----
`timescale 1ns/1ps
// read-only apb view of the latched bytes and load status
module apb_cfg_regs
    import cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [7:0] byte_zero,
    input wire logic [7:0] byte_one,
    input wire logic [7:0] byte_two,
    input wire logic [7:0] status,
    output logic [31:0] prdata,
    output logic pslverr
);
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } regs_t;
    regs_t cur, next_cur;

    // decode on the setup cycle so read data is ready in the access phase
    always_comb begin
        next_cur = cur;
        if (psel && !penable) begin
            next_cur.err = 1'b0;
            if (paddr == OFS_BYTE_ZERO) begin
                next_cur.rdata = {24'h0, byte_zero};
            end else if (paddr == OFS_BYTE_ONE) begin
                next_cur.rdata = {24'h0, byte_one};
            end else if (paddr == OFS_BYTE_TWO) begin
                next_cur.rdata = {24'h0, byte_two};
            end else if (paddr == OFS_STATUS) begin
                next_cur.rdata = {24'h0, status};
            end else begin
                // unmapped: error, data zero
                next_cur.rdata = ZERO_WORD;
                next_cur.err = 1'b1;
            end
            // all registers are read-only, writes are refused
            if (pwrite) begin
                next_cur.err = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.rdata;
    assign pslverr = cur.err;
endmodule // apb_cfg_regs

// ---- rtl/chip_config_byte_decode.sv ----
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module chip_config_byte_decode
    import cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic large_variant,
    output mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output cfg_out_t cfg,
    output logic cfg_valid
);
    // whole module state
    typedef struct packed {
        load_state_t st;
        mem_req_t req;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic third_fetched;
        cfg_out_t cfg;
        logic valid;
        logic pready;
        logic variant_s1; // strap, first synchroniser stage, read by nothing else
        logic variant_s2; // strap, second stage, safe to decode
    } state_t;
    state_t cur, next_cur;

    cfg_out_t dec; // combinational decode of the captured bytes
    logic [7:0] status; // load status word for software

    cfg_decode u_dec (
        .byte_zero(cur.b0),
        .byte_one(cur.b1),
        .byte_two(cur.b2),
        .large_variant(cur.variant_s2),
        .dec(dec)
    );

    // loader: one pass per reset, read bytes then latch decode
    always_comb begin
        next_cur = cur;
        // answer every setup cycle in the following access cycle
        next_cur.pready = psel && !penable;
        // strap crosses from the pin domain through two stages
        next_cur.variant_s1 = large_variant;
        next_cur.variant_s2 = cur.variant_s1;
        case (cur.st)
            ST_IDLE: begin
                // one cycle moves the strap into the first of its two synchroniser stages
                next_cur.st = ST_REQ0;
            end
            ST_REQ0: begin
                next_cur.req.req = 1'b1;
                next_cur.req.addr = ADDR_BYTE_ZERO;
                next_cur.st = ST_WAIT0;
            end
            ST_WAIT0: begin
                if (mem_ack) begin
                    next_cur.b0 = mem_rdata;
                    next_cur.req.req = 1'b0;
                    next_cur.st = ST_REQ1;
                end
            end
            ST_REQ1: begin
                next_cur.req.req = 1'b1;
                next_cur.req.addr = ADDR_BYTE_ONE;
                next_cur.st = ST_WAIT1;
            end
            ST_WAIT1: begin
                if (mem_ack) begin
                    next_cur.b1 = mem_rdata;
                    next_cur.req.req = 1'b0;
                    // third byte only on the large part with fetch flag set
                    if (mem_rdata[B1_FETCH_THIRD] && cur.variant_s2) begin
                        next_cur.st = ST_REQ2;
                    end else begin
                        next_cur.st = ST_DONE;
                    end
                end
            end
            ST_REQ2: begin
                next_cur.req.req = 1'b1;
                next_cur.req.addr = ADDR_BYTE_TWO;
                next_cur.st = ST_WAIT2;
            end
            ST_WAIT2: begin
                if (mem_ack) begin
                    next_cur.b2 = mem_rdata;
                    next_cur.third_fetched = 1'b1;
                    next_cur.req.req = 1'b0;
                    next_cur.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // latch once, then hold until the next reset
                if (!cur.valid) begin
                    next_cur.cfg = dec;
                    next_cur.valid = 1'b1;
                end
            end
            default: begin
                next_cur.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur.st <= ST_IDLE;
            cur.req <= '0;
            cur.b0 <= BYTE_ERASED;
            cur.b1 <= BYTE_ERASED;
            cur.b2 <= BYTE_TWO_DEFAULT;
            cur.third_fetched <= 1'b0;
            cur.cfg <= '0;
            cur.valid <= 1'b0;
            cur.pready <= 1'b0;
            cur.variant_s1 <= 1'b0;
            cur.variant_s2 <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign status = {5'h0, cur.cfg.cfg_error, cur.third_fetched, cur.valid};

    apb_cfg_regs u_regs (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .byte_zero(cur.b0),
        .byte_one(cur.b1),
        .byte_two(cur.b2),
        .status(status),
        .prdata(prdata),
        .pslverr(pslverr)
    );

    assign mem_req = cur.req;
    assign pready = cur.pready;
    assign cfg = cur.cfg;
    assign cfg_valid = cur.valid;

    // assertions
    property p_held;
        @(posedge ref_clk) disable iff (!rstn)
        cur.valid |=> $stable(cur.cfg) && cur.valid;
    endproperty
    a_held: assert property (p_held) else $error("settings changed after latch");

    property p_mode0_wait;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid && cfg.timing_mode == TIMING_MODE0 |-> cfg.auto_wait == AUTO_WAIT_MODE0;
    endproperty
    a_mode0_wait: assert property (p_mode0_wait) else $error("mode 0 lacks wait");

    property p_mode3_wait;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid && cfg.timing_mode == TIMING_MODE3 |-> cfg.auto_wait == AUTO_WAIT_NONE;
    endproperty
    a_mode3_wait: assert property (p_mode3_wait) else $error("mode 3 adds wait");

    property p_no_third;
        @(posedge ref_clk) disable iff (!rstn)
        cur.st == ST_WAIT1 && mem_ack && !mem_rdata[B1_FETCH_THIRD] |=> cur.st == ST_DONE;
    endproperty
    a_no_third: assert property (p_no_third) else $error("third byte fetched");

    property p_third_addr;
        @(posedge ref_clk) disable iff (!rstn)
        cur.st == ST_WAIT2 |-> mem_req.addr == ADDR_BYTE_TWO && mem_req.req;
    endproperty
    a_third_addr: assert property (p_third_addr) else $error("third byte address");

    property p_mirror;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cfg_valid) |-> cfg.low_segment_mirror == $past(cur.b2[B2_MIRROR]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror bit mismatch");

    property p_addr_width;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cfg_valid) |-> cfg.addr_width_select == $past(cur.b2[B2_ADDR_WIDTH]);
    endproperty
    a_addr_width: assert property (p_addr_width) else $error("address width mismatch");

    property p_ready_unl;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cfg_valid) |-> cfg.ready_unlimited ==
            ($past(cur.b1[B1_READY2]) && $past(cur.b0[B0_READY1]) && $past(cur.b0[B0_READY0]));
    endproperty
    a_ready_unl: assert property (p_ready_unl) else $error("ready limit decode");

    property p_width;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cfg_valid) |-> cfg.width_mode ==
            {$past(cur.b1[B1_WIDTH_HIGH]), $past(cur.b0[B0_WIDTH_LOW])};
    endproperty
    a_width: assert property (p_width) else $error("width decode");

    property p_lock;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cfg_valid) |-> cfg.prot == prot_t'({$past(cur.b0[B0_LOCK1]), $past(cur.b0[B0_LOCK0])});
    endproperty
    a_lock: assert property (p_lock) else $error("lock decode");

    // an open request keeps its address until the memory answers
    sequence s_req_open;
        mem_req.req && !mem_ack;
    endsequence
    property p_req_hold;
        @(posedge ref_clk) disable iff (!rstn)
        s_req_open |=> mem_req.req && $stable(mem_req.addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");

    // an answered request is released for one idle cycle
    sequence s_answer;
        mem_req.req && mem_ack;
    endsequence
    property p_req_release;
        @(posedge ref_clk) disable iff (!rstn)
        s_answer |=> !mem_req.req;
    endproperty
    a_req_release: assert property (p_req_release) else $error("request held on");

    // last byte in, one cycle to the done state, then the settings latch
    sequence s_last_byte;
        mem_ack && (cur.st == ST_WAIT2 || (cur.st == ST_WAIT1
            && !(mem_rdata[B1_FETCH_THIRD] && cur.variant_s2)));
    endsequence
    property p_latch_time;
        @(posedge ref_clk) disable iff (!rstn)
        s_last_byte |=> !cfg_valid ##1 cfg_valid;
    endproperty
    a_latch_time: assert property (p_latch_time) else $error("late latch");

    // flag set on the large part: byte two is asked for two cycles later
    sequence s_flag_seen;
        cur.st == ST_WAIT1 && mem_ack && mem_rdata[B1_FETCH_THIRD] && cur.variant_s2;
    endsequence
    property p_third_fetch;
        @(posedge ref_clk) disable iff (!rstn)
        s_flag_seen |=> ##1 mem_req.req && mem_req.addr == ADDR_BYTE_TWO;
    endproperty
    a_third_fetch: assert property (p_third_fetch) else $error("third byte missed");

    // the small part has no third byte, so it never asks for one
    property p_small_no_third;
        @(posedge ref_clk) disable iff (!rstn)
        !cur.variant_s2 |-> !(mem_req.req && mem_req.addr == ADDR_BYTE_TWO);
    endproperty
    a_small_no_third: assert property (p_small_no_third) else $error("byte two asked");

    // the small part always runs the standard timing mode
    property p_small_mode3;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid && !cur.variant_s2 |-> cfg.timing_mode == TIMING_MODE3;
    endproperty
    a_small_mode3: assert property (p_small_mode3) else $error("small part timing");

    // reserved timing codes must never pass silently
    property p_timing_resv;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid && cfg.timing_mode != TIMING_MODE0 && cfg.timing_mode != TIMING_MODE3
            |-> cfg.cfg_error;
    endproperty
    a_timing_resv: assert property (p_timing_resv) else $error("bad timing unflagged");

    // the illegal width code must never pass silently
    property p_width_illegal;
        @(posedge ref_clk) disable iff (!rstn)
        cfg_valid && cfg.width_mode == WIDTH_ILLEGAL |-> cfg.cfg_error;
    endproperty
    a_width_illegal: assert property (p_width_illegal) else $error("bad width unflagged");

    // without the top ready bit the wait limit is zero
    property p_ready_zero;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cfg_valid) && !$past(cur.b1[B1_READY2])
            |-> cfg.ready_max == READY_ZERO && !cfg.ready_unlimited;
    endproperty
    a_ready_zero: assert property (p_ready_zero) else $error("ready limit not zero");

    // held in reset every output rests low
    property p_reset_quiet;
        @(posedge ref_clk)
        !rstn |-> !cfg_valid && !mem_req.req && !pready && !pslverr;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");

    // every setup cycle is answered in the access cycle after it
    sequence s_setup;
        psel && !penable;
    endsequence
    property p_apb_answer;
        @(posedge ref_clk) disable iff (!rstn)
        s_setup |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no ready in access");
endmodule // chip_config_byte_decode

// ---- test/cfg_mem_model.sv ----
`timescale 1ns/1ps
// configuration memory behind the loader; answers after a chosen delay
module cfg_mem_model
    import cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input mem_req_t mem_req,
    input wire logic [23:0] bytes,
    input wire logic [1:0] delay,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    output int req_cnt,
    output logic order_bad
);
    logic [1:0] wait_cnt; // cycles left before the answer
    logic done; // answered, waiting for req to drop
    logic [15:0] want; // address expected next
    // one answer per request, data toggles when not answering
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h5A;
            req_cnt <= 0;
            order_bad <= 1'b0;
            wait_cnt <= 2'h0;
            done <= 1'b0;
            want <= ADDR_BYTE_ZERO;
        end else begin
            mem_ack <= 1'b0;
            // released data line must not look like the last byte
            mem_rdata <= ~mem_rdata;
            if (!mem_req.req) begin
                done <= 1'b0;
                wait_cnt <= delay;
            end else if (!done && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (!done) begin
                done <= 1'b1;
                mem_ack <= 1'b1;
                req_cnt <= req_cnt + 1;
                if (mem_req.addr !== want) begin
                    order_bad <= 1'b1;
                end
                want <= want + 16'h0002;
                case (mem_req.addr)
                    ADDR_BYTE_ZERO: mem_rdata <= bytes[7:0];
                    ADDR_BYTE_ONE: mem_rdata <= bytes[15:8];
                    ADDR_BYTE_TWO: mem_rdata <= bytes[23:16];
                    default: mem_rdata <= 8'hFF;
                endcase
            end
        end
    end
endmodule // cfg_mem_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import cfg_pkg::*;
;
    typedef struct packed {logic [31:0] d; logic e; logic dchk;} apb_exp_t;
    logic ref_clk, rstn, large_variant, mem_ack, psel, penable, pwrite, pready, pslverr;
    logic cfg_valid, order_bad, cfg_seen;
    mem_req_t mem_req;
    logic [7:0] mem_rdata, b0, b1, b2;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [23:0] mem_bytes;
    logic [1:0] dly;
    cfg_out_t cfg, ce, got; // watcher copies
    cfg_out_t he, hg; // main process copies, never touched by the watcher
    int req_cnt, error_cnt, compares, seed, i, n;
    apb_exp_t apb_q[$]; // expected apb answers, oldest first
    cfg_out_t cfg_q[$]; // expected latched settings
    apb_exp_t ax;
    chip_config_byte_decode i_chip_config_byte_decode (.ref_clk(ref_clk), .rstn(rstn),
        .large_variant(large_variant), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .cfg_valid(cfg_valid));
    cfg_mem_model i_cfg_mem_model (.ref_clk(ref_clk), .rstn(rstn), .mem_req(mem_req),
        .bytes(mem_bytes), .delay(dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .req_cnt(req_cnt), .order_bad(order_bad));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one apb transfer; psel stays up so the next may follow at once
    task automatic apb(input logic wr, input logic [15:0] a, input apb_exp_t x);
        int k;
        apb_q.push_back(x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= $random(seed);
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            complete_run();
        end
    endtask
    // own model of the decode, independent of the design
    function automatic cfg_out_t expect_cfg(input logic [7:0] z, o, t, input logic big);
        cfg_out_t e;
        logic [2:0] rc;
        logic f;
        f = big & o[0];
        e.timing_mode = big ? o[7:6] : 2'h3;
        e.auto_wait = (e.timing_mode == 2'h0) ? 2'h1 : 2'h0;
        rc = {o[1], z[5:4]};
        e.ready_unlimited = (rc == 3'h7);
        e.ready_max = rc[2] ? {1'b0, rc[1:0]} + 3'h1 : 3'h0;
        e.width_mode = {o[2], z[1]};
        e.addr_width_select = f & t[1];
        e.low_segment_mirror = f & t[2];
        e.prot = prot_t'(z[7:6]);
        e.cfg_error = (e.timing_mode == 2'h1) | (e.timing_mode == 2'h2) |
            (e.width_mode == 2'h0) | (rc != 3'h0 && !rc[2]) | (f && (t & 8'hF9) != 8'hF8);
        return e;
    endfunction
    // watcher: apb answers and the moment settings latch
    always @(posedge ref_clk) begin
        if (!rstn) cfg_seen = 1'b0;
        if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
            ax = apb_q.pop_front();
            check("pslverr", {31'h0, ax.e}, {31'h0, pslverr});
            if (ax.dchk) check("prdata", ax.d, prdata);
        end
        if (cfg_valid === 1'b1 && !cfg_seen && cfg_q.size() > 0) begin
            cfg_seen = 1'b1;
            ce = cfg_q.pop_front();
            got = cfg;
            // the limit count is meaningless when unlimited
            if (ce.ready_unlimited) got.ready_max = ce.ready_max;
            check("cfg", {17'h0, ce}, {17'h0, got});
        end
    end
    initial begin
        seed = 32'ha85c;
        error_cnt = 0;
        compares = 0;
        rstn <= 1'b0;
        large_variant <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 16'h0000;
        pwdata <= 32'h0000_0000;
        mem_bytes <= 24'hFFFFFF;
        dly <= 2'h0;
        for (i = 0; i < 12; i++) begin
            r = $random(seed);
            b0 = r[7:0];
            b0[7:6] = i[1:0] + 2'h2;
            b0[1] = i[0] ^ i[2];
            b0[5:4] = i[1:0];
            b1 = r[15:8];
            b1[7:6] = i[1:0];
            b1[2] = i[1] ^ i[3];
            b1[1] = i[2];
            b1[0] = r[16] | i[0];
            b2 = {5'h1F, r[18:17], (i == 7)};
            rstn <= 1'b0;
            large_variant <= (i % 3 != 0);
            mem_bytes <= {b2, b1, b0};
            dly <= r[20:19];
            repeat (2) @(posedge ref_clk);
            check("reset", 32'h0, {30'h0, cfg_valid, mem_req.req});
            cfg_q.push_back(expect_cfg(b0, b1, b2, i % 3 != 0));
            rstn <= 1'b1;
            n = 0;
            while (cfg_valid !== 1'b1 && n < 200) begin
                @(posedge ref_clk);
                n++;
            end
            if (n >= 200) begin
                error_cnt++;
                complete_run();
            end
            he = expect_cfg(b0, b1, b2, i % 3 != 0);
            check("reads", (i % 3 != 0 && b1[0]) ? 3 : 2, req_cnt);
            check("order", 32'h0, {31'h0, order_bad});
            @(posedge ref_clk);
            apb(1'b0, OFS_BYTE_ZERO, '{{24'h0, b0}, 1'b0, 1'b1});
            apb(1'b0, OFS_BYTE_ONE, '{{24'h0, b1}, 1'b0, 1'b1});
            apb(1'b0, OFS_BYTE_TWO, '{{24'h0, (i % 3 != 0 && b1[0]) ? b2 : 8'hF8}, 1'b0, 1'b1});
            apb(1'b0, OFS_STATUS, '{{29'h0, he.cfg_error, i % 3 != 0 && b1[0], 1'b1}, 1'b0, 1'b1});
            apb(1'b0, 16'h2028, '{32'h0, 1'b1, 1'b1});
            apb(1'b1, OFS_BYTE_TWO, '{32'h0, 1'b1, 1'b0});
            psel <= 1'b0;
            penable <= 1'b0;
            // memory changes after latching must not reach the settings
            mem_bytes <= ~{b2, b1, b0};
            repeat (10) @(posedge ref_clk);
            hg = cfg;
            if (he.ready_unlimited) hg.ready_max = he.ready_max;
            check("held", {17'h0, he}, {17'h0, hg});
            check("held reads", (i % 3 != 0 && b1[0]) ? 3 : 2, req_cnt);
        end
        complete_run();
    end
endmodule // testbench
